// ===== rlt_pkg.sv
package rlt_pkg;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [31:0] KEY_TOP_ADDR    = 32'h400000d0;
   localparam logic [31:0] BLOCK_PTR_ADDR  = 32'h400000d4;
   localparam logic [31:0] TX_MIC_ADDR     = 32'h400000d8;
   localparam logic [31:0] RX_MIC_ADDR     = 32'h400000dc;
   localparam logic [31:0] TEST_CTRL_ADDR  = 32'h400000e0;
   localparam logic [31:0] TX_COUNT_ADDR   = 32'h400000e4;
   localparam logic [31:0] RX_COUNT_ADDR   = 32'h400000e8;
   localparam logic [31:0] CIPHER_CTL_ADDR = 32'h400000ec;
   localparam logic [31:0] TIMING_ADDR     = 32'h400000f0;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int ENDLESS_RX_BIT   = 31;
   localparam int RX_COUNT_EN_BIT  = 27;
   localparam int ENDLESS_TX_BIT   = 15;
   localparam int SIZE_SRC_BIT     = 14;
   localparam int PRBS_KIND_BIT    = 13;
   localparam int CONTENT_SRC_BIT  = 12;
   localparam int TX_COUNT_EN_BIT  = 11;
   localparam int BYTES_LSB        = 0;
   localparam int BYTES_W          = 9;
   localparam int POINTER_W        = 16;
   localparam int EARLY_ABORT_BIT  = 31;
   localparam int ABORT_LSB        = 16;
   localparam int ABORT_W          = 10;
   localparam int PREFETCH_LSB     = 0;
   localparam int PREFETCH_W       = 9;
   localparam int CIPHER_START_BIT = 0;
   localparam int TEST_ACTIVE_BIT  = 8;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [31:0] WORD_RESET       = 32'h00000000;
   localparam logic        EARLY_ABORT_RST  = 1'h1;
   localparam logic [9:0]  ABORT_RST        = 10'h1fe;
   localparam logic [8:0]  PREFETCH_RST     = 9'h096;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic       endless_receive_window;
      logic       receive_count_enable;
      logic       endless_transmit_payload;
      logic       payload_size_source;
      logic       pseudo_random_kind;
      logic       payload_content_source;
      logic       transmit_count_enable;
      logic [8:0] test_payload_bytes;
   } rlt_test_ctrl_t;

   typedef struct packed {
      logic       early_abort_enable;
      logic [9:0] abort_instant_us;
      logic [8:0] prefetch_instant_us;
   } rlt_timing_t;

endpackage : rlt_pkg

// ===== rlt_regs.sv
`timescale 1ns/100ps
module rlt_regs #(
   parameter int COUNT_W = 32
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  rf_test_mode,
   input  wire logic                  tx_packet_done,
   input  wire logic                  rx_packet_done,
   input  wire logic                  rx_sync_error,
   input  wire logic                  rx_crc_error,
   input  wire logic                  rf_abort,
   input  wire logic                  tx_mic_valid,
   input  wire logic [31:0]           tx_mic_value,
   input  wire logic                  rx_mic_valid,
   input  wire logic [31:0]           rx_mic_value,
   input  wire logic                  crypto_done,
   input  wire logic [8:0]            descriptor_length_field,
   output logic      [31:0]           key_upper_word,
   output logic      [15:0]           cipher_block_pointer_field,
   output logic                       cipher_start,
   output rlt_pkg::rlt_test_ctrl_t    test_ctrl_out,
   output logic      [8:0]            payload_bytes,
   output rlt_pkg::rlt_timing_t       timing_out,
   output logic      [31:0]           structure_transmit_total,
   output logic      [31:0]           structure_receive_total,
   output logic                       structure_total_write
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   generate
      if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_width
         $error("COUNT_W must lie between 1 and 32");
      end
   endgenerate

   // ************************************************************
   // Storage
   // ************************************************************
   rlt_pkg::rlt_test_ctrl_t test_ctrl;
   rlt_pkg::rlt_timing_t    timing;
   logic [31:0]             key_top;
   logic [15:0]             block_ptr;
   logic [31:0]             tx_mic;
   logic [31:0]             rx_mic;
   logic [31:0]             transmitted_packet_total;
   logic [31:0]             received_packet_total;
   logic [COUNT_W-1:0]      tx_live;
   logic [COUNT_W-1:0]      rx_live;
   logic                    start_flag;
   logic                    wr_en;
   logic                    setup;
   logic                    tx_step;
   logic                    rx_step;
   logic [COUNT_W-1:0]      next_tx_live;
   logic [COUNT_W-1:0]      next_rx_live;
   logic [31:0]             read_word;
   logic                    mapped;

   function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
      hit = (addr == target);
   endfunction : hit

   function automatic logic [31:0] widen(input logic [COUNT_W-1:0] value);
      logic [31:0] w;
      w = 32'h00000000;
      w[COUNT_W-1:0] = value;
      widen = w;
   endfunction : widen

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;

   // ************************************************************
   // Read decode
   // ************************************************************
   always_comb begin
      read_word = 32'h00000000;
      mapped    = 1'b1;
      if (hit(paddr, rlt_pkg::KEY_TOP_ADDR)) begin
         read_word = key_top;
      end else if (hit(paddr, rlt_pkg::BLOCK_PTR_ADDR)) begin
         read_word[15:0] = block_ptr;
      end else if (hit(paddr, rlt_pkg::TX_MIC_ADDR)) begin
         read_word = tx_mic;
      end else if (hit(paddr, rlt_pkg::RX_MIC_ADDR)) begin
         read_word = rx_mic;
      end else if (hit(paddr, rlt_pkg::TEST_CTRL_ADDR)) begin
         read_word[rlt_pkg::ENDLESS_RX_BIT]  = test_ctrl.endless_receive_window;
         read_word[rlt_pkg::RX_COUNT_EN_BIT] = test_ctrl.receive_count_enable;
         read_word[rlt_pkg::ENDLESS_TX_BIT]  = test_ctrl.endless_transmit_payload;
         read_word[rlt_pkg::SIZE_SRC_BIT]    = test_ctrl.payload_size_source;
         read_word[rlt_pkg::PRBS_KIND_BIT]   = test_ctrl.pseudo_random_kind;
         read_word[rlt_pkg::CONTENT_SRC_BIT] = test_ctrl.payload_content_source;
         read_word[rlt_pkg::TX_COUNT_EN_BIT] = test_ctrl.transmit_count_enable;
         read_word[rlt_pkg::BYTES_LSB +: rlt_pkg::BYTES_W] = test_ctrl.test_payload_bytes;
      end else if (hit(paddr, rlt_pkg::TX_COUNT_ADDR)) begin
         read_word = transmitted_packet_total;
      end else if (hit(paddr, rlt_pkg::RX_COUNT_ADDR)) begin
         read_word = received_packet_total;
      end else if (hit(paddr, rlt_pkg::CIPHER_CTL_ADDR)) begin
         read_word[rlt_pkg::CIPHER_START_BIT] = start_flag;
         read_word[rlt_pkg::TEST_ACTIVE_BIT]  = rf_test_mode;
      end else if (hit(paddr, rlt_pkg::TIMING_ADDR)) begin
         read_word[rlt_pkg::EARLY_ABORT_BIT] = timing.early_abort_enable;
         read_word[rlt_pkg::ABORT_LSB +: rlt_pkg::ABORT_W] = timing.abort_instant_us;
         read_word[rlt_pkg::PREFETCH_LSB +: rlt_pkg::PREFETCH_W] = timing.prefetch_instant_us;
      end else begin
         mapped = 1'b0;
      end
   end

   // ************************************************************
   // Bus answer
   // ************************************************************
   // The answer is prepared in the setup cycle so that every bus output comes
   // from a flip-flop; this costs exactly one access cycle per transfer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= !mapped;
         prdata  <= pwrite ? 32'h00000000 : read_word;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
   end

   // ************************************************************
   // Writable registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_top   <= rlt_pkg::WORD_RESET;
         block_ptr <= rlt_pkg::WORD_RESET[15:0];
      end else if (wr_en && hit(paddr, rlt_pkg::KEY_TOP_ADDR)) begin
         key_top <= pwdata;
      end else if (wr_en && hit(paddr, rlt_pkg::BLOCK_PTR_ADDR)) begin
         block_ptr <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_ctrl <= '0;
      end else if (wr_en && hit(paddr, rlt_pkg::TEST_CTRL_ADDR)) begin
         test_ctrl.endless_receive_window   <= pwdata[rlt_pkg::ENDLESS_RX_BIT];
         test_ctrl.receive_count_enable     <= pwdata[rlt_pkg::RX_COUNT_EN_BIT];
         test_ctrl.endless_transmit_payload <= pwdata[rlt_pkg::ENDLESS_TX_BIT];
         test_ctrl.payload_size_source      <= pwdata[rlt_pkg::SIZE_SRC_BIT];
         test_ctrl.pseudo_random_kind       <= pwdata[rlt_pkg::PRBS_KIND_BIT];
         test_ctrl.payload_content_source   <= pwdata[rlt_pkg::CONTENT_SRC_BIT];
         test_ctrl.transmit_count_enable    <= pwdata[rlt_pkg::TX_COUNT_EN_BIT];
         test_ctrl.test_payload_bytes <= pwdata[rlt_pkg::BYTES_LSB +: rlt_pkg::BYTES_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing.early_abort_enable  <= rlt_pkg::EARLY_ABORT_RST;
         timing.abort_instant_us    <= rlt_pkg::ABORT_RST;
         timing.prefetch_instant_us <= rlt_pkg::PREFETCH_RST;
      end else if (wr_en && hit(paddr, rlt_pkg::TIMING_ADDR)) begin
         timing.early_abort_enable  <= pwdata[rlt_pkg::EARLY_ABORT_BIT];
         timing.abort_instant_us <= pwdata[rlt_pkg::ABORT_LSB +: rlt_pkg::ABORT_W];
         timing.prefetch_instant_us <= pwdata[rlt_pkg::PREFETCH_LSB +: rlt_pkg::PREFETCH_W];
      end
   end

   // A start written in the same cycle as a completion wins, so a new block
   // request is never lost behind the end of the previous one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_flag <= 1'b0;
      end else if (wr_en && hit(paddr, rlt_pkg::CIPHER_CTL_ADDR)
                   && pwdata[rlt_pkg::CIPHER_START_BIT]) begin
         start_flag <= 1'b1;
      end else if (crypto_done) begin
         start_flag <= 1'b0;
      end
   end

   // ************************************************************
   // Integrity values
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_mic <= rlt_pkg::WORD_RESET;
      end else if (tx_mic_valid) begin
         tx_mic <= tx_mic_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_mic <= rlt_pkg::WORD_RESET;
      end else if (rx_mic_valid) begin
         rx_mic <= rx_mic_value;
      end
   end

   // ************************************************************
   // Test packet counters
   // ************************************************************
   assign tx_step = rf_test_mode && test_ctrl.transmit_count_enable && tx_packet_done;
   assign rx_step = rf_test_mode && test_ctrl.receive_count_enable && rx_packet_done
                    && !rx_sync_error && !rx_crc_error;
   assign next_tx_live = tx_live + COUNT_W'(tx_step);
   assign next_rx_live = rx_live + COUNT_W'(rx_step);

   // A packet finishing on the abort cycle is still included in the report.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_live <= '0;
         rx_live <= '0;
      end else if (rf_abort) begin
         tx_live <= '0;
         rx_live <= '0;
      end else begin
         tx_live <= next_tx_live;
         rx_live <= next_rx_live;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmitted_packet_total <= rlt_pkg::WORD_RESET;
         received_packet_total    <= rlt_pkg::WORD_RESET;
         structure_transmit_total <= rlt_pkg::WORD_RESET;
         structure_receive_total  <= rlt_pkg::WORD_RESET;
         structure_total_write    <= 1'b0;
      end else begin
         structure_total_write <= rf_abort && rf_test_mode
                                  && (test_ctrl.transmit_count_enable
                                      || test_ctrl.receive_count_enable);
         if (rf_abort && rf_test_mode && test_ctrl.transmit_count_enable) begin
            transmitted_packet_total <= widen(next_tx_live);
            structure_transmit_total <= widen(next_tx_live);
         end
         if (rf_abort && rf_test_mode && test_ctrl.receive_count_enable) begin
            received_packet_total   <= widen(next_rx_live);
            structure_receive_total <= widen(next_rx_live);
         end
      end
   end

   // ************************************************************
   // Outputs to the link layer
   // ************************************************************
   // Outside test mode every option is forced off, so stale settings left by
   // software cannot disturb normal traffic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_ctrl_out <= '0;
         payload_bytes <= 9'h000;
      end else begin
         test_ctrl_out <= rf_test_mode ? test_ctrl : '0;
         if (rf_test_mode && test_ctrl.payload_size_source) begin
            payload_bytes <= test_ctrl.test_payload_bytes;
         end else begin
            payload_bytes <= descriptor_length_field;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_upper_word             <= rlt_pkg::WORD_RESET;
         cipher_block_pointer_field <= rlt_pkg::WORD_RESET[15:0];
         cipher_start               <= 1'b0;
         timing_out.early_abort_enable  <= rlt_pkg::EARLY_ABORT_RST;
         timing_out.abort_instant_us    <= rlt_pkg::ABORT_RST;
         timing_out.prefetch_instant_us <= rlt_pkg::PREFETCH_RST;
      end else begin
         key_upper_word             <= key_top;
         cipher_block_pointer_field <= block_ptr;
         cipher_start               <= start_flag;
         timing_out                 <= timing;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_bus_answer_one: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("access phase not answered in exactly one cycle");

   a_start_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit(paddr, rlt_pkg::CIPHER_CTL_ADDR) && pwdata[0]) |=> ##1 cipher_start)
      else $error("cipher start write lost");

   a_start_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (crypto_done && !wr_en) |=> !start_flag ##1 !cipher_start)
      else $error("start bit not cleared on completion");

   a_test_gating: assert property (@(posedge pclk) disable iff (!presetn)
      !rf_test_mode |=> (test_ctrl_out == '0))
      else $error("test option active outside test mode");

   a_length_pick: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> payload_bytes == (($past(rf_test_mode) && $past(test_ctrl.payload_size_source))
               ? $past(test_ctrl.test_payload_bytes) : $past(descriptor_length_field)))
      else $error("payload length source wrong");

   a_rx_error_skip: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_packet_done && (rx_sync_error || rx_crc_error) && !rf_abort) |=> $stable(rx_live))
      else $error("errored packet counted");

   a_tx_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_step && !rf_abort) |=> tx_live == $past(tx_live) + COUNT_W'(1))
      else $error("transmit count did not advance");

   a_abort_report: assert property (@(posedge pclk) disable iff (!presetn)
      (rf_abort && rf_test_mode && test_ctrl.transmit_count_enable)
      |=> structure_total_write && transmitted_packet_total == structure_transmit_total
          && tx_live == '0)
      else $error("transmit total not reported on abort");

   a_timing_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit(paddr, rlt_pkg::TIMING_ADDR))
      |=> ##1 timing_out.abort_instant_us == $past(pwdata[25:16], 2))
      else $error("abort instant not taken");

   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit(paddr, rlt_pkg::BLOCK_PTR_ADDR)) |=> prdata[31:16] == 16'h0000)
      else $error("reserved pointer bits read nonzero");

endmodule : rlt_regs

// ===== tb.sv
`timescale 1ns/100ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, tx_mic, rx_mic, key_out, tx_tot, rx_tot;
   logic        test_mode, tx_done, rx_done, sync_err, crc_err, abort_cmd;
   logic        tx_mic_ld, rx_mic_ld, crypto_done, start_out, tot_wr;
   logic [15:0] ptr_out;
   logic [8:0]  desc_len, pay_bytes;
   rlt_pkg::rlt_test_ctrl_t ctrl_out;
   rlt_pkg::rlt_timing_t    tim_out;
   int          err_total, tests_run, ntx, nrx;
   logic [33:0] expq[$];
   logic [33:0] x;
   logic [31:0] r, ctl, key, tim;
   logic [31:0] amap[9] = '{rlt_pkg::KEY_TOP_ADDR, rlt_pkg::BLOCK_PTR_ADDR,
      rlt_pkg::TX_MIC_ADDR, rlt_pkg::RX_MIC_ADDR, rlt_pkg::TEST_CTRL_ADDR,
      rlt_pkg::TX_COUNT_ADDR, rlt_pkg::RX_COUNT_ADDR, rlt_pkg::CIPHER_CTL_ADDR,
      rlt_pkg::TIMING_ADDR};

   rlt_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rf_test_mode(test_mode), .tx_packet_done(tx_done),
      .rx_packet_done(rx_done), .rx_sync_error(sync_err), .rx_crc_error(crc_err),
      .rf_abort(abort_cmd), .tx_mic_valid(tx_mic_ld), .tx_mic_value(tx_mic),
      .rx_mic_valid(rx_mic_ld), .rx_mic_value(rx_mic), .crypto_done(crypto_done),
      .descriptor_length_field(desc_len), .key_upper_word(key_out),
      .cipher_block_pointer_field(ptr_out), .cipher_start(start_out),
      .test_ctrl_out(ctrl_out), .payload_bytes(pay_bytes), .timing_out(tim_out),
      .structure_transmit_total(tx_tot), .structure_receive_total(rx_tot),
      .structure_total_write(tot_wr));

   // ************************************************************
   // Checking and bus tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // The expectation is queued before the access phase; the monitor pops it.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      expq.push_back({~wr, er, e});
      @(posedge pclk);
      penable <= 1'b1;
      // No wait-state count is assumed; only the watchdog ends a stuck access.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         x = expq.pop_front();
         chk("pslverr", {31'h0, x[32]}, {31'h0, pslverr});
         if (x[33])
            chk("prdata", x[31:0], prdata);
      end
   end

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   initial begin
      repeat (5000) @(posedge pclk);
      err_total++;
      tally_and_finish();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, test_mode, tx_done} = '0;
      {rx_done, sync_err, crc_err, abort_cmd, tx_mic_ld, rx_mic_ld} = '0;
      {crypto_done, tx_mic, rx_mic, desc_len, err_total, tests_run} = '0;
      r = $urandom(95);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++)
         apb(0, amap[i], 0, (i == 8) ? 32'h81fe0096 : 32'h0, 0);
      apb(0, 32'h400000fc, 0, 0, 1);
      apb(1, 32'h400000f8, 32'hffffffff, 0, 1);
      key = $urandom;
      apb(1, amap[0], key, 0, 0);
      apb(0, amap[0], 0, key, 0);
      chk("key_out", key, key_out);
      r = $urandom;
      apb(1, amap[1], r, 0, 0);
      apb(0, amap[1], 0, r & 32'hffff, 0);
      chk("ptr_out", r & 32'hffff, {16'h0, ptr_out});
      tim = $urandom;
      apb(1, amap[8], tim, 0, 0);
      apb(0, amap[8], 0, tim & 32'h83ff01ff, 0);
      chk("tim_out", {12'h0, tim[31], tim[25:16], tim[8:0]}, {12'h0, tim_out});
      apb(1, amap[4], 32'hffffffff, 0, 0);
      apb(0, amap[4], 0, 32'h8800f9ff, 0);
      for (int i = 2; i < 7; i += (i == 3) ? 2 : 1) begin
         apb(1, amap[i], $urandom, 0, 0);
         apb(0, amap[i], 0, 0, 0);
      end
      @(posedge pclk);
      {tx_mic_ld, rx_mic_ld, tx_mic, rx_mic} <= {2'b11, $urandom, $urandom};
      @(posedge pclk);
      {tx_mic_ld, rx_mic_ld} <= 2'b00;
      apb(0, amap[2], 0, tx_mic, 0);
      apb(0, amap[3], 0, rx_mic, 0);
      for (int i = 0; i < 8; i++) begin
         ctl = $urandom;
         ctl[14:12] = {i[0], i[1:0]};
         test_mode <= i[2];
         desc_len <= 9'($urandom);
         apb(1, amap[4], ctl, 0, 0);
         repeat (3) @(posedge pclk);
         chk("ctrl_out", i[2] ? {ctl[31], ctl[27], ctl[15:11], ctl[8:0]} : 0, ctrl_out);
         chk("pay_bytes", (i[2] && i[0]) ? ctl[8:0] : desc_len, pay_bytes);
      end
      apb(1, amap[4], 32'h08000800, 0, 0);
      {ntx, nrx} = '0;
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         @(posedge pclk);
         {tx_done, rx_done, sync_err, crc_err} <= r[3:0];
         ntx += r[3];
         nrx += r[2] & ~r[1] & ~r[0];
      end
      @(posedge pclk);
      {tx_done, rx_done, sync_err, crc_err, abort_cmd} <= 5'b00001;
      @(posedge pclk);
      abort_cmd <= 1'b0;
      #1;
      chk("tot_wr", 1, tot_wr);
      chk("tx_tot", ntx, tx_tot);
      chk("rx_tot", nrx, rx_tot);
      apb(0, amap[5], 0, ntx, 0);
      apb(0, amap[6], 0, nrx, 0);
      test_mode <= 1'b0;
      @(posedge pclk);
      {tx_done, abort_cmd} <= 2'b10;
      @(posedge pclk);
      {tx_done, abort_cmd} <= 2'b01;
      @(posedge pclk);
      abort_cmd <= 1'b0;
      #1;
      chk("tot_wr", 0, tot_wr);
      chk("tx_tot", ntx, tx_tot);
      apb(0, amap[5], 0, ntx, 0);
      apb(1, amap[7], 32'h1, 0, 0);
      apb(0, amap[7], 0, 32'h1, 0);
      chk("start_out", 1, start_out);
      @(posedge pclk);
      crypto_done <= 1'b1;
      @(posedge pclk);
      crypto_done <= 1'b0;
      apb(0, amap[7], 0, 32'h0, 0);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(0, amap[8], 0, 32'h81fe0096, 0);
      apb(0, amap[0], 0, 32'h0, 0);
      repeat (2) @(posedge pclk);
      tally_and_finish();
   end
endmodule : tb
